// >>> design/mctt_edge.sv
// Edge detector with selectable polarity, one-cycle pulse
`timescale 1ns/1ns
module mctt_edge (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lvl,
  input wire logic rise,
  output logic pulse
);
  logic prev_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= lvl;
    end
  end

  assign pulse = rise ? (lvl & ~prev_r) : (~lvl & prev_r);
endmodule

// >>> design/mctt_pkg.sv
// Types shared by the measure counter, counter/timer and trigger logic
package mctt_pkg;

  typedef enum logic [3:0] {
    MS_CONV = 4'h0,
    MS_TACH = 4'h1,
    MS_DIN0 = 4'h2,
    MS_DIN7 = 4'h9,
    MS_CTCLK = 4'hA,
    MS_CTGATE = 4'hB
  } mctt_msrc_e;

  typedef enum logic [1:0] {
    TS_SW = 2'h0,
    TS_DIN = 2'h1,
    TS_THR = 2'h2
  } mctt_tsrc_e;

  typedef enum logic [0:0] {
    TG_IDLE = 1'b0,
    TG_ARMED = 1'b1
  } mctt_tstate_e;

  typedef struct packed {
    logic [13:0] rsvd;
    logic stream_en;
    logic meas_en;
    logic [2:0] rsvd1;
    logic stop_rise;
    logic [3:0] stop_src;
    logic [2:0] rsvd2;
    logic start_rise;
    logic [3:0] start_src;
  } mctt_mcfg_s;

  typedef struct packed {
    logic [21:0] rsvd;
    logic sw_gate;
    logic [2:0] gate_sel;
    logic gate_ext;
    logic [2:0] clk_sel;
    logic clk_ext;
    logic enable;
  } mctt_ctcfg_s;

  typedef struct packed {
    logic [15:0] level;
    logic [7:0] rsvd;
    logic [1:0] ain_sel;
    logic rise;
    logic [2:0] din_sel;
    logic [1:0] src;
  } mctt_tcfg_s;

endpackage

// >>> design/mctt_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef MCTT_REGS_SVH
`define MCTT_REGS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define MCTT_ADDR_W 8
`define MCTT_OFS_MEAS_CFG 8'h00
`define MCTT_OFS_MEAS_RES 8'h04
`define MCTT_OFS_CT_CFG 8'h08
`define MCTT_OFS_CT_DIV 8'h0C
`define MCTT_OFS_CT_CNT 8'h10
`define MCTT_OFS_DOUT_CFG 8'h14
`define MCTT_OFS_TRIG_CFG 8'h18
`define MCTT_OFS_TRIG_CMD 8'h1C

// ****************************************
// Field positions
// ****************************************
`define MCTT_CMD_SW_BIT 0
`define MCTT_CMD_ARM_BIT 1
`define MCTT_CMD_DISARM_BIT 2

// ****************************************
// Reset values
// ****************************************
`define MCTT_MEAS_CFG_RST 32'h0000_0000
`define MCTT_CT_CFG_RST 32'h0000_0000
`define MCTT_CT_DIV_RST 32'h0000_0001
`define MCTT_DOUT_CFG_RST 32'h0000_0000
`define MCTT_TRIG_CFG_RST 32'h0000_0000

// ****************************************
// Timing and scaling
// ****************************************
`define MCTT_SYS_MHZ 125
`define MCTT_REF_MHZ 48
`define MCTT_DIV_MIN 32'h0000_0001
`define MCTT_STREAM_CH 3'h6
`define MCTT_HYST_MV 100
`define MCTT_SPAN_MV 20000
`define MCTT_HYST_CODES ((`MCTT_HYST_MV * (1 << 16)) / `MCTT_SPAN_MV)

`endif

// >>> design/mctt_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module mctt_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// >>> design/mctt_top.sv
// Measure counter, general counter/timer and acquisition trigger
// How it works
// RULE_01 - 31-bit count of 48 MHz reference ticks
// RULE_02 - Start/stop sources selectable, polarity each
// RULE_03 - Stream sample lands at channel six
// RULE_04 - One 32-bit counter, divider 2 to 2^32
// RULE_05 - Counter clock internal or DIN, gate selectable
// RULE_06 - Counter output routable to outputs 11-18
// RULE_07 - Trigger from software, DIN or threshold
// RULE_08 - Digital trigger is edge, polarity selectable
// RULE_09 - Threshold crossing with 100 mV hysteresis
// RULE_10 - Acquisition starts within one conversion period
// RULE_11 - Clear on start, latch on stop
`timescale 1ns/1ns
`include "mctt_regs.svh"
module mctt_top
  import mctt_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic [7:0] DIN,
  input wire logic TACH_IN,
  input wire logic CONV_DONE,
  input wire logic SAMPLE_CLK,
  input wire logic ADC_VALID,
  input wire logic [1:0] ADC_CH,
  input wire logic [15:0] ADC_DATA,
  output logic [7:0] DOUT,
  output logic STREAM_VALID,
  output logic [2:0] STREAM_CHAN,
  output logic [31:0] STREAM_DATA,
  output logic ACQ_START,
  output logic ACQ_ARMED
);

  // ****************************************
  // Register file
  // ****************************************
  mctt_mcfg_s mcfg_r;
  mctt_ctcfg_s ctcfg_r;
  mctt_tcfg_s tcfg_r;
  logic [31:0] ct_div_r;
  logic [15:0] dout_cfg_r;
  logic [30:0] meas_cnt_r;
  logic [30:0] meas_res_r;
  logic meas_run_r;
  logic [31:0] ct_cnt_r;
  logic cmd_wr;
  logic sw_trig;
  logic arm_cmd;
  logic disarm_cmd;

  assign cmd_wr = WR && (ADDR == `MCTT_OFS_TRIG_CMD);
  assign sw_trig = cmd_wr && WDATA[`MCTT_CMD_SW_BIT];
  assign arm_cmd = cmd_wr && WDATA[`MCTT_CMD_ARM_BIT];
  assign disarm_cmd = cmd_wr && WDATA[`MCTT_CMD_DISARM_BIT];

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mcfg_r <= `MCTT_MEAS_CFG_RST;
      ctcfg_r <= `MCTT_CT_CFG_RST;
      tcfg_r <= `MCTT_TRIG_CFG_RST;
      ct_div_r <= `MCTT_CT_DIV_RST;
      dout_cfg_r <= 16'h0000;
    end else if (WR) begin
      case (ADDR)
        `MCTT_OFS_MEAS_CFG: mcfg_r <= WDATA;
        `MCTT_OFS_CT_CFG: ctcfg_r <= WDATA;
        `MCTT_OFS_TRIG_CFG: tcfg_r <= WDATA;
        // Stored as divisor minus one; zero would mean divide by one
        `MCTT_OFS_CT_DIV: ct_div_r <= (WDATA < `MCTT_DIV_MIN) ? `MCTT_DIV_MIN : WDATA; // RULE_04
        `MCTT_OFS_DOUT_CFG: dout_cfg_r <= WDATA[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      case (ADDR)
        `MCTT_OFS_MEAS_CFG: RDATA <= mcfg_r;
        `MCTT_OFS_MEAS_RES: RDATA <= {meas_run_r, meas_res_r};
        `MCTT_OFS_CT_CFG: RDATA <= ctcfg_r;
        `MCTT_OFS_CT_DIV: RDATA <= ct_div_r;
        `MCTT_OFS_CT_CNT: RDATA <= ct_cnt_r;
        `MCTT_OFS_DOUT_CFG: RDATA <= {16'h0000, dout_cfg_r};
        `MCTT_OFS_TRIG_CFG: RDATA <= tcfg_r;
        `MCTT_OFS_TRIG_CMD: RDATA <= {31'h0000_0000, ACQ_ARMED};
        default: RDATA <= 32'h0000_0000;
      endcase
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Pin synchronisers and 48 MHz reference
  // ****************************************
  logic [7:0] din_s;
  logic tach_s;
  logic [6:0] ref_acc_r;
  logic [7:0] ref_sum;
  logic ref_tick;

  mctt_sync #(.W(9)) u_sync (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .d({TACH_IN, DIN}),
    .q({tach_s, din_s})
  );

  // Fractional accumulator: 48 ticks per 125 system cycles, jitter one cycle
  assign ref_sum = {1'b0, ref_acc_r} + 8'(`MCTT_REF_MHZ);
  assign ref_tick = ref_sum >= 8'(`MCTT_SYS_MHZ);

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ref_acc_r <= 7'h00;
    end else begin
      ref_acc_r <= ref_tick ? 7'(ref_sum - 8'(`MCTT_SYS_MHZ)) : ref_sum[6:0]; // RULE_01
    end
  end

  // ****************************************
  // Measure counter
  // ****************************************
  logic ct_clk_lvl;
  logic ct_gate_lvl;
  logic start_lvl;
  logic stop_lvl;
  logic start_p;
  logic stop_p;

  assign ct_clk_lvl = din_s[ctcfg_r.clk_sel];
  assign ct_gate_lvl = din_s[ctcfg_r.gate_sel];

  function automatic logic src_level(input logic [3:0] s, input logic conv, input logic tach,
                                     input logic [7:0] din, input logic ck, input logic gt);
    logic r;
    r = 1'b0;
    case (s)
      MS_CONV: r = conv;
      MS_TACH: r = tach;
      MS_CTCLK: r = ck;
      MS_CTGATE: r = gt;
      default: r = (s >= MS_DIN0 && s <= MS_DIN7) ? din[3'(s - MS_DIN0)] : 1'b0;
    endcase
    return r;
  endfunction

  assign start_lvl = src_level(mcfg_r.start_src, CONV_DONE, tach_s, din_s, ct_clk_lvl, ct_gate_lvl); // RULE_02
  assign stop_lvl = src_level(mcfg_r.stop_src, CONV_DONE, tach_s, din_s, ct_clk_lvl, ct_gate_lvl); // RULE_02

  mctt_edge u_start_edge (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .lvl(start_lvl),
    .rise(mcfg_r.start_rise),
    .pulse(start_p)
  );

  mctt_edge u_stop_edge (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .lvl(stop_lvl),
    .rise(mcfg_r.stop_rise),
    .pulse(stop_p)
  );

  // Stop is taken first, so one source can end a period and open the next
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      meas_cnt_r <= 31'h0000_0000;
      meas_res_r <= 31'h0000_0000;
      meas_run_r <= 1'b0;
    end else if (!mcfg_r.meas_en) begin
      meas_run_r <= 1'b0;
    end else begin
      if (stop_p && meas_run_r) begin
        meas_res_r <= meas_cnt_r; // RULE_11
      end
      if (start_p) begin
        meas_cnt_r <= 31'h0000_0000; // RULE_11
        meas_run_r <= 1'b1;
      end else if (stop_p && meas_run_r) begin
        meas_run_r <= 1'b0;
      end else if (meas_run_r && ref_tick) begin
        meas_cnt_r <= meas_cnt_r + 31'h0000_0001; // RULE_01
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      STREAM_VALID <= 1'b0;
      STREAM_CHAN <= 3'h0;
      STREAM_DATA <= 32'h0000_0000;
    end else begin
      STREAM_VALID <= SAMPLE_CLK && mcfg_r.stream_en;
      if (SAMPLE_CLK && mcfg_r.stream_en) begin
        STREAM_CHAN <= `MCTT_STREAM_CH; // RULE_03
        STREAM_DATA <= {1'b0, meas_res_r}; // RULE_03
      end
    end
  end

  // ****************************************
  // General counter/timer
  // ****************************************
  logic ct_ext_p;
  logic ct_tick;
  logic ct_gate;
  logic [32:0] ct_half;
  logic [31:0] ct_cnt_nxt;
  logic ct_out_r;

  mctt_edge u_ct_clk_edge (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .lvl(ct_clk_lvl),
    .rise(1'b1),
    .pulse(ct_ext_p)
  );

  assign ct_tick = ctcfg_r.clk_ext ? ct_ext_p : ref_tick; // RULE_05
  assign ct_gate = ctcfg_r.gate_ext ? ct_gate_lvl : ctcfg_r.sw_gate; // RULE_05
  assign ct_half = ({1'b0, ct_div_r} + 33'h0_0000_0001) >> 1;
  assign ct_cnt_nxt = (ct_cnt_r >= ct_div_r) ? 32'h0000_0000 : ct_cnt_r + 32'h0000_0001; // RULE_04

  // High for the first half of each divided period
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ct_cnt_r <= 32'h0000_0000;
      ct_out_r <= 1'b0;
    end else if (!ctcfg_r.enable) begin
      ct_cnt_r <= 32'h0000_0000;
      ct_out_r <= 1'b0;
    end else if (ct_tick && ct_gate) begin
      ct_cnt_r <= ct_cnt_nxt;
      ct_out_r <= {1'b0, ct_cnt_nxt} < ct_half;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      DOUT <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        DOUT[i] <= dout_cfg_r[8 + i] ? ct_out_r : dout_cfg_r[i]; // RULE_06
      end
    end
  end

  // ****************************************
  // Acquisition trigger
  // ****************************************
  mctt_tstate_e tstate_r;
  logic trig_din_p;
  logic thr_ready_r;
  logic thr_sel;
  logic signed [16:0] smp;
  logic signed [16:0] lvl;
  logic signed [16:0] hyst;
  logic thr_arm_cond;
  logic thr_hit;
  logic fire;

  mctt_edge u_trig_edge (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .lvl(din_s[tcfg_r.din_sel]),
    .rise(tcfg_r.rise),
    .pulse(trig_din_p)
  );

  assign thr_sel = ADC_VALID && (ADC_CH == tcfg_r.ain_sel);
  assign smp = {ADC_DATA[15], ADC_DATA};
  assign lvl = {tcfg_r.level[15], tcfg_r.level};
  assign hyst = 17'(`MCTT_HYST_CODES);
  // Must first go past the level by the hysteresis band before a crossing counts
  assign thr_arm_cond = tcfg_r.rise ? (smp < lvl - hyst) : (smp > lvl + hyst); // RULE_09
  assign thr_hit = thr_sel && thr_ready_r && (tcfg_r.rise ? (smp >= lvl) : (smp <= lvl)); // RULE_09

  always_comb begin
    case (tcfg_r.src)
      TS_SW: fire = sw_trig; // RULE_07
      TS_DIN: fire = trig_din_p; // RULE_08
      TS_THR: fire = thr_hit; // RULE_07
      default: fire = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      thr_ready_r <= 1'b0;
    end else if (thr_sel && thr_arm_cond) begin
      thr_ready_r <= 1'b1; // RULE_09
    end else if (arm_cmd || thr_hit) begin
      thr_ready_r <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tstate_r <= TG_IDLE;
      ACQ_ARMED <= 1'b0;
      ACQ_START <= 1'b0;
    end else begin
      ACQ_START <= 1'b0;
      case (tstate_r)
        TG_IDLE: begin
          if (arm_cmd) begin
            tstate_r <= TG_ARMED;
            ACQ_ARMED <= 1'b1;
          end
        end
        TG_ARMED: begin
          if (disarm_cmd) begin
            tstate_r <= TG_IDLE;
            ACQ_ARMED <= 1'b0;
          end else if (fire) begin
            tstate_r <= TG_IDLE;
            ACQ_ARMED <= 1'b0;
            ACQ_START <= 1'b1; // RULE_10
          end
        end
        default: begin
          tstate_r <= TG_IDLE;
          ACQ_ARMED <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_measure_open;
    mcfg_r.meas_en && start_p;
  endsequence

  a_ref_spacing: assert property (ref_tick |=> !ref_tick) else $error("reference tick too fast"); // RULE_01
  a_meas_count: assert property (mcfg_r.meas_en && meas_run_r && ref_tick && !start_p && !stop_p
    |=> meas_cnt_r == $past(meas_cnt_r) + 31'h0000_0001) else $error("measure count missed tick"); // RULE_01
  a_meas_clear: assert property (s_measure_open |=> meas_cnt_r == 31'h0000_0000 && meas_run_r)
    else $error("start did not clear count"); // RULE_11
  a_meas_latch: assert property (mcfg_r.meas_en && stop_p && meas_run_r |=> meas_res_r == $past(meas_cnt_r))
    else $error("stop did not latch count"); // RULE_11
  a_src_mux: assert property (mcfg_r.start_src == MS_TACH |-> start_lvl == tach_s)
    else $error("start source mux wrong"); // RULE_02
  a_stream_ch6: assert property (SAMPLE_CLK && mcfg_r.stream_en
    |=> STREAM_VALID && STREAM_CHAN == 3'h6 && STREAM_DATA == {1'b0, $past(meas_res_r)})
    else $error("stream sample wrong"); // RULE_03
  a_div_floor: assert property (ct_div_r >= 32'h0000_0001) else $error("divider below two"); // RULE_04
  a_ct_wrap: assert property (ctcfg_r.enable && ct_tick && ct_gate && ct_cnt_r >= ct_div_r
    |=> ct_cnt_r == 32'h0000_0000) else $error("counter did not wrap"); // RULE_04
  a_ct_gate_hold: assert property (ctcfg_r.enable && !ct_gate |=> $stable(ct_cnt_r))
    else $error("counter moved while gated off"); // RULE_05
  a_dout_route: assert property (dout_cfg_r[8] |=> DOUT[0] == $past(ct_out_r))
    else $error("output route wrong"); // RULE_06
  a_sw_start: assert property (tstate_r == TG_ARMED && tcfg_r.src == TS_SW && sw_trig && !disarm_cmd
    |=> ACQ_START ##1 !ACQ_START) else $error("software trigger lost"); // RULE_07
  a_din_edge: assert property (tstate_r == TG_ARMED && tcfg_r.src == TS_DIN && !trig_din_p && !disarm_cmd
    |=> !ACQ_START) else $error("digital trigger not edge based"); // RULE_08
  a_thr_band: assert property ($rose(thr_ready_r) |-> $past(thr_sel && thr_arm_cond)) else $error("ready without band"); // RULE_09
  a_trig_delay: assert property (tstate_r == TG_ARMED && fire && !disarm_cmd |=> ACQ_START && !ACQ_ARMED)
    else $error("acquisition start late"); // RULE_10

endmodule

// >>> dv/mctt_ext_model.sv
// Far-side model: connector pins and acquisition sample path
`timescale 1ns/1ns
module mctt_ext_model (
  input wire logic clk,
  output logic [7:0] din,
  output logic tach,
  output logic conv_done,
  output logic sample_clk,
  output logic adc_valid,
  output logic [1:0] adc_ch,
  output logic [15:0] adc_data
);
  // Digital inputs rest high through their pull-ups
  initial begin
    din = 8'hFF;
    tach = 1'b0;
    conv_done = 1'b0;
    sample_clk = 1'b0;
    adc_valid = 1'b0;
    adc_ch = 2'h0;
    adc_data = 16'h0000;
  end
  task automatic set_din(input logic [2:0] i, input logic v, input int hold);
    @(posedge clk);
    din <= (din & ~(8'h01 << i)) | ({7'h00, v} << i);
    repeat (hold) @(posedge clk);
  endtask
  task automatic set_tc(input logic t, input logic c, input int hold);
    @(posedge clk);
    tach <= t;
    conv_done <= c;
    repeat (hold) @(posedge clk);
  endtask
  task automatic sample_pulse();
    @(posedge clk);
    sample_clk <= 1'b1;
    @(posedge clk);
    sample_clk <= 1'b0;
  endtask
  // Outside the strobe the sample is invalid, so it must not look stable
  task automatic adc_put(input logic [1:0] ch, input logic [15:0] d);
    @(posedge clk);
    adc_valid <= 1'b1;
    adc_ch <= ch;
    adc_data <= d;
    @(posedge clk);
    adc_valid <= 1'b0;
    adc_ch <= ~ch;
    adc_data <= ~d;
  endtask
endmodule

// >>> dv/mctt_tb.sv
// Self-checking bench for measure counter, counter/timer and trigger
`timescale 1ns/1ns
`include "mctt_regs.svh"
module testbench;
  logic sys_clk;
  logic rst_n;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [7:0] din;
  logic tach, conv_done, sample_clk, adc_valid;
  logic [1:0] adc_ch;
  logic [15:0] adc_data;
  logic [7:0] dout;
  logic stream_valid;
  logic [2:0] stream_chan;
  logic [31:0] stream_data;
  logic acq_start;
  logic acq_armed;
  int bad_count;
  int tests_run;

  mctt_top u_dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .DIN(din), .TACH_IN(tach), .CONV_DONE(conv_done), .SAMPLE_CLK(sample_clk),
    .ADC_VALID(adc_valid), .ADC_CH(adc_ch), .ADC_DATA(adc_data), .DOUT(dout),
    .STREAM_VALID(stream_valid), .STREAM_CHAN(stream_chan), .STREAM_DATA(stream_data),
    .ACQ_START(acq_start), .ACQ_ARMED(acq_armed));
  mctt_ext_model u_ext (.clk(sys_clk), .din(din), .tach(tach), .conv_done(conv_done),
    .sample_clk(sample_clk), .adc_valid(adc_valid), .adc_ch(adc_ch), .adc_data(adc_data));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi, input string what);
    tests_run++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h not in %h..%h", $time, what, got, lo, hi);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic starts_in(input int n, output int s);
    s = 0;
    // First look falls in the cycle launched by the caller's last edge
    #1 if (acq_start === 1'b1) s++;
    repeat (n - 1) begin
      @(posedge sys_clk);
      #1 if (acq_start === 1'b1) s++;
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    logic [31:0] v;
    logic [7:0] a [8];
    logic [31:0] e [8];
    a = '{`MCTT_OFS_MEAS_CFG, `MCTT_OFS_MEAS_RES, `MCTT_OFS_CT_CFG, `MCTT_OFS_CT_DIV,
      `MCTT_OFS_CT_CNT, `MCTT_OFS_DOUT_CFG, `MCTT_OFS_TRIG_CFG, 8'h20};
    e = '{`MCTT_MEAS_CFG_RST, 32'h0, `MCTT_CT_CFG_RST, `MCTT_CT_DIV_RST, 32'h0,
      `MCTT_DOUT_CFG_RST, `MCTT_TRIG_CFG_RST, 32'h0};
    chk({24'h0, dout}, 32'h0, "dout after reset");
    for (int i = 0; i < 8; i++) begin
      reg_rd(a[i], v);
      chk(v, e[i], "reset value");
    end
    @(posedge sys_clk);
    #1 chk(rdata, 32'h0, "read data held");
    reg_wr(`MCTT_OFS_CT_DIV, 32'h0);
    reg_rd(`MCTT_OFS_CT_DIV, v);
    chk(v, `MCTT_DIV_MIN, "divider floor");
    reg_wr(`MCTT_OFS_CT_DIV, 32'hFFFF_FFFF);
    reg_rd(`MCTT_OFS_CT_DIV, v);
    chk(v, 32'hFFFF_FFFF, "divider ceiling");
    reg_wr(`MCTT_OFS_MEAS_RES, 32'h1234_5678);
    reg_wr(8'h24, 32'hFFFF_FFFF);
    reg_rd(`MCTT_OFS_MEAS_RES, v);
    chk(v, 32'h0, "read-only result");
    reg_rd(`MCTT_OFS_TRIG_CFG, v);
    chk(v, 32'h0, "unmapped write");
  endtask

  task automatic t_meas();
    logic [31:0] v;
    int h;
    int ex;
    for (int r = 0; r < 2; r++) begin
      h = 250 + 250 * r;
      ex = (h + 1) * `MCTT_REF_MHZ / `MCTT_SYS_MHZ;
      reg_wr(`MCTT_OFS_MEAS_CFG, 32'h0003_1302 | {27'h0, r[0], 4'h0});
      u_ext.set_din(3'h0, ~r[0], 2);
      u_ext.set_din(3'h1, 1'b0, 6);
      u_ext.set_din(3'h0, r[0], h);
      u_ext.set_din(3'h1, 1'b1, 8);
      reg_rd(`MCTT_OFS_MEAS_RES, v);
      chk_rng(v, ex - 2, ex + 2, "interval count");
    end
    u_ext.sample_pulse();
    #1 chk({31'h0, stream_valid}, 32'h1, "stream valid");
    chk({29'h0, stream_chan}, {29'h0, `MCTT_STREAM_CH}, "stream chan");
    chk_rng(stream_data, ex - 2, ex + 2, "stream data");
    @(posedge sys_clk);
    #1 chk({31'h0, stream_valid}, 32'h0, "stream pulse");
    // Tach start, conversion-complete stop; the tach path adds two sync cycles
    reg_wr(`MCTT_OFS_MEAS_CFG, 32'h0003_1011);
    u_ext.set_tc(1'b1, 1'b0, 250);
    u_ext.set_tc(1'b1, 1'b1, 8);
    reg_rd(`MCTT_OFS_MEAS_RES, v);
    ex = 249 * `MCTT_REF_MHZ / `MCTT_SYS_MHZ;
    chk_rng(v, ex - 2, ex + 2, "tach to conv interval");
  endtask

  task automatic t_ct();
    logic [31:0] v;
    reg_wr(`MCTT_OFS_CT_DIV, 32'h0000_0003);
    reg_wr(`MCTT_OFS_DOUT_CFG, 32'h0000_F105);
    reg_wr(`MCTT_OFS_CT_CFG, 32'h0000_020B);
    u_ext.set_din(3'h2, 1'b0, 6);
    for (int k = 1; k < 7; k++) begin
      u_ext.set_din(3'h2, 1'b1, 6);
      u_ext.set_din(3'h2, 1'b0, 6);
      reg_rd(`MCTT_OFS_CT_CNT, v);
      chk(v, k % 4, "counter");
      chk({24'h0, dout}, (k % 4 < 2) ? 32'hF5 : 32'h04, "routed output");
    end
    // Gate closed by software, then opened from input 3
    reg_wr(`MCTT_OFS_CT_CFG, 32'h0000_000B);
    u_ext.set_din(3'h2, 1'b1, 6);
    u_ext.set_din(3'h2, 1'b0, 6);
    reg_rd(`MCTT_OFS_CT_CNT, v);
    chk(v, 32'h2, "gated off");
    reg_wr(`MCTT_OFS_CT_CFG, 32'h0000_00EB);
    u_ext.set_din(3'h2, 1'b1, 6);
    reg_rd(`MCTT_OFS_CT_CNT, v);
    chk(v, 32'h3, "external gate");
    reg_wr(`MCTT_OFS_CT_CFG, 32'h0);
    reg_rd(`MCTT_OFS_CT_CNT, v);
    chk(v, 32'h0, "disable clears");
    chk({24'h0, dout}, 32'h04, "output cleared");
  endtask

  task automatic t_trig_sw();
    logic [31:0] v;
    int s;
    reg_wr(`MCTT_OFS_TRIG_CFG, 32'h0);
    reg_wr(`MCTT_OFS_TRIG_CMD, 32'h1);
    starts_in(4, s);
    chk(s, 0, "unarmed fire");
    reg_wr(`MCTT_OFS_TRIG_CMD, 32'h2);
    #1 chk({31'h0, acq_armed}, 32'h1, "armed");
    reg_rd(`MCTT_OFS_TRIG_CMD, v);
    chk(v, 32'h1, "armed readback");
    reg_wr(`MCTT_OFS_TRIG_CMD, 32'h1);
    #1 chk({30'h0, acq_start, acq_armed}, 32'h2, "software start");
    @(posedge sys_clk);
    #1 chk({31'h0, acq_start}, 32'h0, "start pulse");
    reg_wr(`MCTT_OFS_TRIG_CMD, 32'h2);
    // Disarm and fire in one write: disarm must win
    reg_wr(`MCTT_OFS_TRIG_CMD, 32'h5);
    #1 chk({31'h0, acq_armed}, 32'h0, "disarm");
    starts_in(3, s);
    chk(s, 0, "disarm beats fire");
  endtask

  task automatic t_trig_din();
    int s;
    for (int r = 1; r >= 0; r--) begin
      reg_wr(`MCTT_OFS_TRIG_CFG, 32'h0000_0011 | {26'h0, r[0], 5'h0});
      u_ext.set_din(3'h4, r[0], 8);
      reg_wr(`MCTT_OFS_TRIG_CMD, 32'h2);
      u_ext.set_din(3'h4, ~r[0], 0);
      starts_in(8, s);
      chk(s, 0, "wrong edge");
      u_ext.set_din(3'h4, r[0], 0);
      starts_in(8, s);
      chk(s, 1, "digital start");
      chk({31'h0, acq_armed}, 32'h0, "armed dropped");
    end
  endtask

  task automatic t_trig_thr();
    int s;
    logic [1:0] c [7];
    logic [15:0] d [7];
    int ex [7];
    c = '{2'h1, 2'h1, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1};
    d = '{16'(1000 - `MCTT_HYST_CODES), 16'd1000, 16'd600, 16'd1000,
      16'(999 - `MCTT_HYST_CODES), 16'd999, 16'd1000};
    ex = '{0, 0, 0, 0, 0, 0, 1};
    reg_wr(`MCTT_OFS_TRIG_CFG, 32'h03E8_0062);
    reg_wr(`MCTT_OFS_TRIG_CMD, 32'h2);
    for (int i = 0; i < 7; i++) begin
      u_ext.adc_put(c[i], d[i]);
      starts_in(4, s);
      chk(s, ex[i], "threshold");
    end
  endtask

  initial begin
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    bad_count = 0;
    tests_run = 0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_meas();
    t_ct();
    t_trig_sw();
    t_trig_din();
    t_trig_thr();
    tally_and_finish();
  end

  // Run limit, far above the cycles the scenarios take
  initial begin
    #640000;
    bad_count++;
    $display("unexpected at %0t: run limit reached", $time);
    tally_and_finish();
  end
endmodule
